// file: src/rpi_defs.svh
// Register offsets, field positions and reset values of the per-port interrupt registers.
// Assumes an 8-bit register address space inside the device, reached through the I2C slave.
`ifndef RPI_DEFS_SVH
`define RPI_DEFS_SVH

// Register offsets
`define RPI_PORT_SELECT_ADDR      8'h4c
`define RPI_IRQ_ENABLE_HIGH_ADDR  8'hd8
`define RPI_IRQ_ENABLE_LOW_ADDR   8'hd9
`define RPI_IRQ_STATUS_HIGH_ADDR  8'hda
`define RPI_IRQ_STATUS_LOW_ADDR   8'hdb

// Reset value of all enable and status registers
`define RPI_IRQ_RESET             8'h00

// Writable and defined bit masks
`define RPI_HIGH_MASK             8'h07
`define RPI_LOW_MASK              8'h77

// High register field positions
`define RPI_BIT_ENCODING_ERROR    2
`define RPI_BIT_CTRL_SEQUENCE     1
`define RPI_BIT_CTRL_CRC          0

// Low register field positions
`define RPI_BIT_LINE_LENGTH       6
`define RPI_BIT_LINE_COUNT        5
`define RPI_BIT_BUFFER_OVERFLOW   4
`define RPI_BIT_LINK_PARITY       2
`define RPI_BIT_PORT_VALID        1
`define RPI_BIT_LOCK_CHANGE       0

`endif

// file: src/rpi_pkg.sv
// Types shared by the per-port interrupt enable and status block.
// Assumes nothing of its surroundings.
package rpi_pkg;

	// Register access from the device's I2C slave
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rpi_reg_req_s;

	// Event strobes of one receive port, one cycle each
	typedef struct packed {
		logic encoding_error;
		logic ctrl_channel_sequence;
		logic ctrl_channel_crc;
		logic line_length_change;
		logic line_count_change;
		logic rx_buffer_overflow;
		logic link_parity;
		logic port_valid_change;
		logic lock_change;
	} rpi_events_s;

	// Which status register a read addressed
	typedef enum logic [1:0] {
		RPI_CLR_NONE,
		RPI_CLR_STATUS_ONE,
		RPI_CLR_STATUS_TWO
	} rpi_clear_e;

endpackage

// file: src/rpi_port_irq.sv
// Per-receive-port interrupt enable and interrupt status registers.
// Assumes the I2C slave presents one-cycle read/write strobes with address and data,
// that the port-select register and the receive status registers live elsewhere,
// and that event inputs are one-cycle pulses synchronous to i_clk.
//
// What this block does
// - Port select steers accesses to per-port copies
// - High enable bit 2 gates encoding error
// - High enable bit 1 gates sequence error
// - High enable bit 0 gates CRC error
// - Low enable bit 6 gates line length
// - Low enable bit 5 gates line count
// - Low enable bit 4 gates buffer overflow
// - Low enable bit 2 gates parity error
// - Low enable bit 1 gates port-valid change
// - Low enable bit 0 gates lock change
// - Encoding flag set, cleared reading status two
// - Sequence flag set, cleared reading status one
// - CRC flag set, cleared reading status one
// - All enables and flags reset to zero
// - Low status mirrors low enable positions
`include "rpi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rpi_port_irq #(
	parameter int NUM_PORTS = 4,
	parameter int SEL_W     = 2
) (
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	// Register access
	input  wire rpi_pkg::rpi_reg_req_s       i_req,
	input  wire logic [NUM_PORTS-1:0]        i_port_read_sel,
	input  wire logic [SEL_W-1:0]            i_port_write_sel,
	output logic      [7:0]                  o_rdata,
	output logic                             o_rhit,
	// Receive status addresses given by the status registers' owner; reads decoded here
	input  wire logic [7:0]                  i_status_one_addr,
	input  wire logic [7:0]                  i_status_two_addr,
	// Events, one entry per port
	input  wire rpi_pkg::rpi_events_s [NUM_PORTS-1:0] i_events,
	// Interrupt requests, one per port
	output logic      [NUM_PORTS-1:0]        o_port_irq
);

	// Refuse a port count that the select index cannot address
	if (NUM_PORTS < 1 || NUM_PORTS > (1 << SEL_W)) begin : g_bad_params
		$error("rpi_port_irq: NUM_PORTS does not fit SEL_W");
	end

	// Per-port storage
	logic [7:0] enable_high_ff [NUM_PORTS];
	logic [7:0] enable_low_ff  [NUM_PORTS];
	logic [7:0] status_high_ff [NUM_PORTS];
	logic [7:0] status_low_ff  [NUM_PORTS];
	logic [7:0] nxt_enable_high [NUM_PORTS];
	logic [7:0] nxt_enable_low  [NUM_PORTS];
	logic [7:0] nxt_status_high [NUM_PORTS];
	logic [7:0] nxt_status_low  [NUM_PORTS];
	logic [7:0] rdata_ff;
	logic       rhit_ff;

	// Pack one port's events into the two status layouts
	function automatic logic [7:0] high_events(input rpi_pkg::rpi_events_s ev);
		logic [7:0] v;
		v = 8'h00;
		v[`RPI_BIT_ENCODING_ERROR] = ev.encoding_error;
		v[`RPI_BIT_CTRL_SEQUENCE]  = ev.ctrl_channel_sequence;
		v[`RPI_BIT_CTRL_CRC]       = ev.ctrl_channel_crc;
		return v;
	endfunction

	function automatic logic [7:0] low_events(input rpi_pkg::rpi_events_s ev);
		logic [7:0] v;
		v = 8'h00;
		v[`RPI_BIT_LINE_LENGTH]     = ev.line_length_change;
		v[`RPI_BIT_LINE_COUNT]      = ev.line_count_change;
		v[`RPI_BIT_BUFFER_OVERFLOW] = ev.rx_buffer_overflow;
		v[`RPI_BIT_LINK_PARITY]     = ev.link_parity;
		v[`RPI_BIT_PORT_VALID]      = ev.port_valid_change;
		v[`RPI_BIT_LOCK_CHANGE]     = ev.lock_change;
		return v;
	endfunction

	// Decode of the access
	wire logic wr_enable_high = i_req.wr && (i_req.addr == `RPI_IRQ_ENABLE_HIGH_ADDR);
	wire logic wr_enable_low  = i_req.wr && (i_req.addr == `RPI_IRQ_ENABLE_LOW_ADDR);
	wire logic rd_status_one  = i_req.rd && (i_req.addr == i_status_one_addr);
	wire logic rd_status_two  = i_req.rd && (i_req.addr == i_status_two_addr);

	// Bits cleared by each status read
	wire logic [7:0] clr_high_one = (8'h01 << `RPI_BIT_CTRL_SEQUENCE) | (8'h01 << `RPI_BIT_CTRL_CRC);
	wire logic [7:0] clr_high_two = 8'h01 << `RPI_BIT_ENCODING_ERROR;
	wire logic [7:0] clr_low_one  = (8'h01 << `RPI_BIT_LINK_PARITY) | (8'h01 << `RPI_BIT_PORT_VALID)
		| (8'h01 << `RPI_BIT_LOCK_CHANGE);
	wire logic [7:0] clr_low_two  = (8'h01 << `RPI_BIT_LINE_LENGTH) | (8'h01 << `RPI_BIT_LINE_COUNT)
		| (8'h01 << `RPI_BIT_BUFFER_OVERFLOW);

	// Next-state per port; an event in the clearing cycle wins over the clear
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			logic sel_rd;
			logic sel_wr;
			logic [7:0] ch;
			logic [7:0] cl;
			sel_rd = i_port_read_sel[p];
			sel_wr = (i_port_write_sel == p[SEL_W-1:0]);
			ch = 8'h00;
			cl = 8'h00;
			if (sel_rd && rd_status_one) begin
				ch = ch | clr_high_one;
				cl = cl | clr_low_one;
			end
			if (sel_rd && rd_status_two) begin
				ch = ch | clr_high_two;
				cl = cl | clr_low_two;
			end
			nxt_status_high[p] = ((status_high_ff[p] & ~ch) | high_events(i_events[p])) & `RPI_HIGH_MASK;
			nxt_status_low[p]  = ((status_low_ff[p] & ~cl) | low_events(i_events[p])) & `RPI_LOW_MASK;
			nxt_enable_high[p] = (sel_wr && wr_enable_high) ? (i_req.wdata & `RPI_HIGH_MASK) : enable_high_ff[p];
			nxt_enable_low[p]  = (sel_wr && wr_enable_low) ? (i_req.wdata & `RPI_LOW_MASK) : enable_low_ff[p];
		end
	end

	// Register update
	always_ff @(posedge i_clk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (i_rst) begin
				enable_high_ff[p] <= `RPI_IRQ_RESET;
				enable_low_ff[p]  <= `RPI_IRQ_RESET;
				status_high_ff[p] <= `RPI_IRQ_RESET;
				status_low_ff[p]  <= `RPI_IRQ_RESET;
			end else begin
				enable_high_ff[p] <= nxt_enable_high[p];
				enable_low_ff[p]  <= nxt_enable_low[p];
				status_high_ff[p] <= nxt_status_high[p];
				status_low_ff[p]  <= nxt_status_low[p];
			end
		end
	end

	// Read mux: lowest selected port answers when several are read-selected
	logic [SEL_W-1:0] rd_port;
	always_comb begin
		rd_port = i_port_write_sel;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			if (i_port_read_sel[p])
				rd_port = p[SEL_W-1:0];
		end
	end

	logic [7:0] nxt_rdata;
	logic       nxt_rhit;
	always_comb begin
		nxt_rhit  = i_req.rd;
		nxt_rdata = 8'h00;
		unique case (i_req.addr)
			`RPI_IRQ_ENABLE_HIGH_ADDR: nxt_rdata = enable_high_ff[rd_port];
			`RPI_IRQ_ENABLE_LOW_ADDR:  nxt_rdata = enable_low_ff[rd_port];
			`RPI_IRQ_STATUS_HIGH_ADDR: nxt_rdata = status_high_ff[rd_port];
			`RPI_IRQ_STATUS_LOW_ADDR:  nxt_rdata = status_low_ff[rd_port];
			default:                   nxt_rhit  = 1'b0;
		endcase
	end

	// Read data registered; it stands until the next read
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= 8'h00;
			rhit_ff  <= 1'b0;
		end else begin
			rhit_ff <= nxt_rhit;
			if (i_req.rd)
				rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_rhit  = rhit_ff;

	// Request level per port
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++)
			o_port_irq[p] = |(status_high_ff[p] & enable_high_ff[p]) | |(status_low_ff[p] & enable_low_ff[p]);
	end

endmodule // rpi_port_irq

`default_nettype wire

// file: sim/rpi_port_irq_assertions.sv
// Port-level checks of the per-port interrupt block.
// Assumes it is bound to rpi_port_irq and sees only its ports.
`include "rpi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rpi_port_irq_assertions #(
	parameter int NUM_PORTS = 4,
	parameter int SEL_W     = 2
) (
	// Clock, reset and the block's ports
	input wire logic                                  i_clk,
	input wire logic                                  i_rst,
	input wire rpi_pkg::rpi_reg_req_s                 i_req,
	input wire logic                                  o_rhit,
	input wire logic [7:0]                            o_rdata,
	input wire rpi_pkg::rpi_events_s [NUM_PORTS-1:0]  i_events,
	input wire logic [NUM_PORTS-1:0]                  o_port_irq
);
	// Address falls inside the block's four registers
	wire logic reg_hit;
	assign reg_hit = i_req.addr >= `RPI_IRQ_ENABLE_HIGH_ADDR && i_req.addr <= `RPI_IRQ_STATUS_LOW_ADDR;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_read_hit: assert property (i_req.rd && reg_hit |=> o_rhit) else $error("no hit");
	chk_miss_zero: assert property (i_req.rd && !reg_hit |=> !o_rhit && o_rdata == 8'h00) else $error("miss");
	chk_hit_cause: assert property (o_rhit |-> $past(i_req.rd)) else $error("stray hit");
	chk_rdata_hold: assert property (!i_req.rd |=> $stable(o_rdata)) else $error("data moved");
	chk_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_port_irq && !o_rhit && !o_rdata)
		else $error("reset");
	chk_irq_rise: assert property ($rose(|o_port_irq) |-> $past(|i_events || i_req.wr)) else $error("rise");
	chk_irq_fall: assert property ($fell(|o_port_irq) |-> $past(i_req.rd || i_req.wr)) else $error("fall");
	chk_irq_steady: assert property (!i_req.rd && !i_req.wr && !i_events |=> $stable(o_port_irq))
		else $error("irq moved");
endmodule // rpi_port_irq_assertions
bind rpi_port_irq rpi_port_irq_assertions #(.NUM_PORTS(NUM_PORTS), .SEL_W(SEL_W)) chk_i (.i_clk(i_clk),
	.i_rst(i_rst), .i_req(i_req), .o_rhit(o_rhit), .o_rdata(o_rdata), .i_events(i_events), .o_port_irq(o_port_irq));
`default_nettype wire

// file: sim/rpi_host_model.sv
// Host side model: issues one-cycle register accesses.
// Assumes four ports; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rpi_host_model (
	// Clock
	input  wire logic            i_clk,
	// Request towards the block
	output rpi_pkg::rpi_reg_req_s o_req,
	output logic [3:0]           o_rsel,
	output logic [1:0]           o_wsel
);
	initial begin
		o_req = '0;
		o_rsel = 4'h0;
		o_wsel = 2'h0;
	end
	// Idle address is inverted so a late sample cannot look valid
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int p);
		@(posedge i_clk);
		#1 o_req = '{w, !w, a, d};
		o_wsel = p[1:0];
		o_rsel = 4'h1 << p;
		@(posedge i_clk);
		#1 o_req = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule // rpi_host_model
`default_nettype wire

// file: sim/rpi_port_irq_tb.sv
// Self-checking bench of the per-port interrupt block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module rpi_port_irq_tb;
	logic                      i_clk = 1'b0;
	logic                      i_rst = 1'b1;
	rpi_pkg::rpi_reg_req_s     req;
	logic [3:0]                rsel;
	logic [1:0]                wsel;
	logic [7:0]                rdata;
	logic                      rhit;
	logic [3:0]                irq;
	rpi_pkg::rpi_events_s [3:0] ev = '0;
	int                        miscompares = 0;
	int                        n_tests = 0;
	int                        cycles = 0;
	// Per event bit: status high, bit position, cleared by status two
	logic [4:0]                map [9] = '{5'h00, 5'h02, 5'h04, 5'h09, 5'h0b, 5'h0d, 5'h10, 5'h12, 5'h15};
	always #2.5 i_clk = ~i_clk;
	// Hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end
	rpi_port_irq rpi_port_irq_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_port_read_sel(rsel),
		.i_port_write_sel(wsel), .o_rdata(rdata), .o_rhit(rhit), .i_status_one_addr(8'h4d),
		.i_status_two_addr(8'h4e), .i_events(ev), .o_port_irq(irq));
	rpi_host_model rpi_host_model_i (.i_clk(i_clk), .o_req(req), .o_rsel(rsel), .o_wsel(wsel));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input int p, input logic [7:0] exp);
		rpi_host_model_i.acc(1'b0, a, 8'h00, p);
		chk(rdata, exp);
	endtask
	task automatic pulse(input int p, input int k);
		@(posedge i_clk);
		#1 ev[p] = rpi_pkg::rpi_events_s'(9'h001 << k);
		@(posedge i_clk);
		#1 ev[p] = '0;
	endtask
	task automatic t_regs();
		for (int a = 8'hd8; a <= 8'hdb; a++) rd(a[7:0], 0, 8'h00);
		rd(8'hdc, 0, 8'h00);
		chk({7'h00, rhit}, 8'h00);
		rpi_host_model_i.acc(1'b1, 8'hd8, 8'hff, 1);
		rpi_host_model_i.acc(1'b1, 8'hd9, 8'hff, 1);
		rpi_host_model_i.acc(1'b1, 8'hda, 8'hff, 1);
		rd(8'hd8, 1, 8'h07);
		chk({7'h00, rhit}, 8'h01);
		rd(8'hd9, 1, 8'h77);
		rd(8'hda, 1, 8'h00);
		rd(8'hd8, 0, 8'h00);
	endtask
	// Every event kind, wrong clear first so the matching read is proven
	task automatic t_events();
		rpi_host_model_i.acc(1'b1, 8'hd8, 8'hff, 2);
		rpi_host_model_i.acc(1'b1, 8'hd9, 8'hff, 2);
		for (int k = 0; k < 9; k++) begin
			pulse(2, k);
			chk({4'h0, irq}, 8'h04);
			rd(map[k][0] ? 8'h4d : 8'h4e, 2, 8'h00);
			chk({4'h0, irq}, 8'h04);
			rd(map[k][4] ? 8'hda : 8'hdb, 2, 8'h01 << map[k][3:1]);
			rd(map[k][0] ? 8'h4e : 8'h4d, 2, 8'h00);
			chk({4'h0, irq}, 8'h00);
		end
	endtask
	task automatic t_mask();
		pulse(3, 0);
		chk({4'h0, irq}, 8'h00);
		rd(8'hdb, 3, 8'h01);
		rpi_host_model_i.acc(1'b1, 8'hd9, 8'h01, 3);
		chk({4'h0, irq}, 8'h08);
		rd(8'h4d, 3, 8'h00);
		chk({4'h0, irq}, 8'h00);
	endtask
	task automatic complete_run();
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		#1 i_rst = 1'b0;
		t_regs();
		t_events();
		t_mask();
		complete_run();
	end
endmodule // rpi_port_irq_tb
`default_nettype wire
